//--- aitp_pkg.sv
/*
  Constants, carriers and state types of the converter's two-wire target
  port. Assumes a 100 MHz core clock and a separate link sampling clock.
*/
package aitp_pkg;

  // ---------------------------------------------------------------
  // Bus codes
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_OPT0 = 7'h48;
  localparam logic [6:0] ADDR_OPT1 = 7'h49;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CODE = 8'h06;
  localparam logic [7:0] GC_ACK_CODE = 8'h04;
  localparam logic [4:0] HS_PREFIX = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int RESULT_W = 16;
  localparam int SIGN_EXT_W = RESULT_W - CODE_W;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] CFG_DEFAULT = 8'h80;
  localparam logic [7:0] CFG_WR_MASK = 8'h13;
  localparam logic [7:0] CFG_BSY_MASK = 8'h80;
  localparam int CFG_BSY_BIT = 7;
  localparam int CFG_SC_BIT = 4;
  localparam logic [1:0] RD_IDX_MSB = 2'h0;
  localparam logic [1:0] RD_IDX_LSB = 2'h1;
  localparam logic [1:0] RD_IDX_CFG = 2'h2;
  localparam logic [1:0] RD_IDX_FILL = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int LINK_PERIOD_PS = 6000;
  localparam int FILT_STD_NS = 50;
  localparam int FILT_HS_NS = 10;
  localparam logic [3:0] FILT_STD_CYC =
    4'((FILT_STD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [3:0] FILT_HS_CYC =
    4'((FILT_HS_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg_rd;
    logic [15:0] result;
  } aitp_mirror_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_WAIT
  } aitp_state_t;

  typedef enum logic [1:0] {
    KIND_ADDR, KIND_WR, KIND_GC
  } aitp_kind_t;

endpackage : aitp_pkg

//--- aitp_target.sv
/*
  Two-wire target port: pin synchronisers and filters, the link-side
  protocol engine on link_clk, and the register side on core_clk.
  Assumes external pull-ups and a controller that owns the serial clock.
*/
`timescale 1ns/1ps

module aitp_line_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw,
  input wire logic [3:0] lim,
  output logic filt_q
);
  logic s1_q;
  logic s2_q;
  logic [3:0] cnt_q;

  // Two-stage synchroniser, then a stability counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      filt_q <= 1'b1;
    end else if (s2_q != filt_q) begin
      if (cnt_q >= lim) begin
        filt_q <= s2_q;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
endmodule : aitp_line_filter

module aitp_target #(
  parameter bit ADDR_SEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_q,
  input wire logic [aitp_pkg::CODE_W-1:0] conv_code,
  input wire logic conv_done,
  input wire logic conv_busy,
  output logic [aitp_pkg::RESULT_W-1:0] result_q,
  output logic [7:0] cfg_q,
  output logic conv_start_q,
  output logic gc_reset_q,
  output logic hs_mode_q
);
  import aitp_pkg::*;

  // ---------------------------------------------------------------
  // Link reset and line conditioning
  // ---------------------------------------------------------------
  localparam logic [6:0] OWN_ADDR = ADDR_SEL ? ADDR_OPT1 : ADDR_OPT0;

  logic lrst_s1;
  logic lrst_b;
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst_b;
    lrst_b <= lrst_s1;
  end

  // Serial clock is only ever observed here
  aitp_line_filter u_scl_filt (
    .clk(link_clk),
    .rst_b(lrst_b),
    .raw(scl_in),
    .lim(hs_mode_q ? FILT_HS_CYC : FILT_STD_CYC),
    .filt_q(scl_f)
  );

  aitp_line_filter u_sda_filt (
    .clk(link_clk),
    .rst_b(lrst_b),
    .raw(sda_in),
    .lim(hs_mode_q ? FILT_HS_CYC : FILT_STD_CYC),
    .filt_q(sda_f)
  );

  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_ev = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // ---------------------------------------------------------------
  // Link-side register mirror
  // ---------------------------------------------------------------
  aitp_mirror_t mir_data_q;
  aitp_mirror_t mir_link_q;
  logic mir_req_q;
  logic mreq_s1;
  logic mreq_s2;
  logic mir_ack_q;
  logic mack_s1;
  logic mack_s2;

  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      mreq_s1 <= 1'b0;
      mreq_s2 <= 1'b0;
      mir_ack_q <= 1'b0;
      mir_link_q <= {CFG_DEFAULT, RESULT_RESET};
    end else begin
      mreq_s1 <= mir_req_q;
      mreq_s2 <= mreq_s1;
      if (mreq_s2 != mir_ack_q) begin
        mir_link_q <= mir_data_q;
        mir_ack_q <= mreq_s2;
      end
    end
  end

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  aitp_state_t st_q;
  aitp_state_t nxt_q;
  aitp_state_t nxt_d;
  aitp_kind_t kind_q;
  aitp_kind_t kind_d;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] rd_idx_q;
  logic [7:0] rd_byte;
  logic mack_q;
  logic wr_done_q;
  logic ack_d;
  logic wr_fire;
  logic gc_fire;
  logic hs_fire;
  logic recv_done;
  logic cfg_tgl_q;
  logic [7:0] cfg_byte_q;
  logic gc_tgl_q;

  assign recv_done = (st_q == ST_RECV) & scl_fall & (bit_q == BYTE_BITS);

  // Byte chosen for the next read slot
  always_comb begin
    unique case (rd_idx_q)
      RD_IDX_MSB: rd_byte = mir_link_q.result[15:8];
      RD_IDX_LSB: rd_byte = mir_link_q.result[7:0];
      RD_IDX_CFG: rd_byte = mir_link_q.cfg_rd;
      RD_IDX_FILL: rd_byte = FILL_BYTE;
    endcase
  end

  // Decision taken once eight bits are
  always_comb begin
    ack_d = 1'b0;
    nxt_d = ST_WAIT;
    kind_d = kind_q;
    wr_fire = 1'b0;
    gc_fire = 1'b0;
    hs_fire = 1'b0;
    unique case (kind_q)
      KIND_ADDR: begin
        if (shift_q[7:3] == HS_PREFIX) begin
          hs_fire = 1'b1;
        end else if (shift_q == GC_ADDR) begin
          ack_d = 1'b1;
          nxt_d = ST_RECV;
          kind_d = KIND_GC;
        end else if (shift_q[7:1] == OWN_ADDR) begin
          ack_d = 1'b1;
          nxt_d = shift_q[0] ? ST_SEND : ST_RECV;
          kind_d = KIND_WR;
        end
      end
      KIND_WR: begin
        nxt_d = ST_RECV;
        ack_d = ~wr_done_q;
        wr_fire = ~wr_done_q;
      end
      KIND_GC: begin
        if (shift_q == GC_RESET_CODE) begin
          ack_d = 1'b1;
          gc_fire = 1'b1;
          nxt_d = ST_RECV;
        end else if (shift_q == GC_ACK_CODE) begin
          ack_d = 1'b1;
          nxt_d = ST_RECV;
        end
      end
      default: begin
        nxt_d = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      kind_q <= KIND_ADDR;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rd_idx_q <= RD_IDX_MSB;
      mack_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= ST_RECV;
      kind_q <= KIND_ADDR;
      bit_q <= 4'h0;
      rd_idx_q <= RD_IDX_MSB;
      wr_done_q <= 1'b0;
    end else if (stop_ev) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_RECV: begin
          if (scl_rise && bit_q != BYTE_BITS) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_q <= bit_q + 4'h1;
          end else if (recv_done) begin
            st_q <= ST_ACK;
            nxt_q <= nxt_d;
            kind_q <= kind_d;
            bit_q <= 4'h0;
            if (wr_fire) begin
              wr_done_q <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_q <= nxt_q;
            if (nxt_q == ST_SEND) begin
              shift_q <= {rd_byte[6:0], 1'b0};
              bit_q <= 4'h1;
              if (rd_idx_q != RD_IDX_FILL) begin
                rd_idx_q <= rd_idx_q + 2'h1;
              end
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_q == BYTE_BITS) begin
              st_q <= ST_MACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f;
          end else if (scl_fall) begin
            if (mack_q) begin
              st_q <= ST_SEND;
              shift_q <= {rd_byte[6:0], 1'b0};
              bit_q <= 4'h1;
              if (rd_idx_q != RD_IDX_FILL) begin
                rd_idx_q <= rd_idx_q + 2'h1;
              end
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        ST_IDLE, ST_WAIT: begin
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // Open-drain data pin: pulled low or released, never driven high
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      if (start_ev || stop_ev) begin
        sda_oe_q <= 1'b0;
      end else if (recv_done) begin
        sda_oe_q <= ack_d;
      end else if (scl_fall && st_q == ST_ACK) begin
        sda_oe_q <= (nxt_q == ST_SEND) & ~rd_byte[7];
      end else if (scl_fall && st_q == ST_SEND) begin
        sda_oe_q <= (bit_q != BYTE_BITS) & ~shift_q[7];
      end else if (scl_fall && st_q == ST_MACK) begin
        sda_oe_q <= mack_q & ~rd_byte[7];
      end
    end
  end

  // Fast filtering and events handed to the core
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      hs_mode_q <= 1'b0;
    end else if (stop_ev) begin
      hs_mode_q <= 1'b0;
    end else if (recv_done && hs_fire) begin
      hs_mode_q <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      cfg_tgl_q <= 1'b0;
      cfg_byte_q <= CFG_DEFAULT;
      gc_tgl_q <= 1'b0;
    end else if (recv_done && !start_ev && !stop_ev) begin
      if (wr_fire) begin
        cfg_tgl_q <= ~cfg_tgl_q;
        cfg_byte_q <= shift_q;
      end
      if (gc_fire) begin
        gc_tgl_q <= ~gc_tgl_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Core side
  // ---------------------------------------------------------------
  logic cfg_s1;
  logic cfg_s2;
  logic cfg_seen_q;
  logic gc_s1;
  logic gc_s2;
  logic gc_seen_q;
  logic cfg_ev;
  logic gc_ev;
  aitp_mirror_t mir_live;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_s1 <= 1'b0;
      cfg_s2 <= 1'b0;
      cfg_seen_q <= 1'b0;
      gc_s1 <= 1'b0;
      gc_s2 <= 1'b0;
      gc_seen_q <= 1'b0;
      mack_s1 <= 1'b0;
      mack_s2 <= 1'b0;
    end else begin
      cfg_s1 <= cfg_tgl_q;
      cfg_s2 <= cfg_s1;
      cfg_seen_q <= cfg_s2;
      gc_s1 <= gc_tgl_q;
      gc_s2 <= gc_s1;
      gc_seen_q <= gc_s2;
      mack_s1 <= mir_ack_q;
      mack_s2 <= mack_s1;
    end
  end

  assign cfg_ev = cfg_s2 ^ cfg_seen_q;
  assign gc_ev = gc_s2 ^ gc_seen_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      result_q <= RESULT_RESET;
    end else if (gc_ev) begin
      result_q <= RESULT_RESET;
    end else if (conv_done) begin
      result_q <= {{SIGN_EXT_W{conv_code[CODE_W-1]}}, conv_code};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_q <= CFG_DEFAULT;
      conv_start_q <= 1'b0;
      gc_reset_q <= 1'b0;
    end else begin
      gc_reset_q <= gc_ev;
      conv_start_q <= cfg_ev & ~gc_ev & cfg_byte_q[CFG_SC_BIT] &
        cfg_byte_q[CFG_BSY_BIT] & ~conv_busy;
      if (gc_ev) begin
        cfg_q <= CFG_DEFAULT;
      end else if (cfg_ev) begin
        cfg_q <= (cfg_byte_q & CFG_WR_MASK) | CFG_BSY_MASK;
      end
    end
  end

  always_comb begin
    mir_live.result = result_q;
    mir_live.cfg_rd = cfg_q;
    mir_live.cfg_rd[CFG_BSY_BIT] = cfg_q[CFG_SC_BIT] ? conv_busy : 1'b1;
  end

  // Handshake carrying the register snapshot to the link side
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mir_req_q <= 1'b0;
      mir_data_q <= {CFG_DEFAULT, RESULT_RESET};
    end else if (mir_req_q == mack_s2 && mir_data_q != mir_live) begin
      mir_data_q <= mir_live;
      mir_req_q <= ~mir_req_q;
    end
  end

endmodule : aitp_target

//--- aitp_target_asserts.sv
/*
  Checker of the two-wire target port, watching only its ports.
  Assumes it is bound into every aitp_target instance.
*/
`timescale 1ns/1ps
module aitp_target_asserts
  import aitp_pkg::*;
#(
  parameter bit ADDR_SEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_q,
  input wire logic sda_oe_q,
  input wire logic [aitp_pkg::CODE_W-1:0] conv_code,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic [aitp_pkg::RESULT_W-1:0] result_q,
  input wire logic [7:0] cfg_q,
  input wire logic conv_start_q,
  input wire logic gc_reset_q,
  input wire logic hs_mode_q
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [15:0] sext_q;
  always_ff @(posedge core_clk) begin
    sext_q <= {{SIGN_EXT_W{conv_code[CODE_W-1]}}, conv_code};
  end
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  // ---------------------------------------------------------------
  // Core side
  // ---------------------------------------------------------------
  AST_RESET_VALUES:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> result_q == RESULT_RESET && cfg_q == CFG_DEFAULT)
    else $error("Register values wrong after reset");
  AST_RESULT_LOAD:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_done |=> result_q == sext_q || result_q == RESULT_RESET)
    else $error("Result not sign extended from code");
  AST_RESULT_HOLD:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (!conv_done && !gc_reset_q) ##1 !gc_reset_q |-> $stable(result_q))
    else $error("Result changed without a load");
  AST_GC_CLEARS:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(gc_reset_q) |-> ##[0:2]
      (result_q == RESULT_RESET && cfg_q == CFG_DEFAULT))
    else $error("General reset did not clear registers");
  AST_GC_PULSE:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    gc_reset_q |=> !gc_reset_q)
    else $error("Reset request longer than one cycle");
  AST_START_SINGLE:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_start_q |=> !conv_start_q ##[0:2] cfg_q[CFG_SC_BIT])
    else $error("Conversion start outside single mode");
  AST_CFG_FORM:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    cfg_q[CFG_BSY_BIT] && (cfg_q & ~(CFG_WR_MASK | CFG_BSY_MASK)) == 8'h00)
    else $error("Configuration holds unwritable bits");
  // ---------------------------------------------------------------
  // Link side
  // ---------------------------------------------------------------
  AST_NO_HIGH_DRIVE:
  assert property (@(posedge link_clk) disable iff (!rst_b)
    sda_out_q == 1'b0)
    else $error("Data pin driven high");
  AST_OE_WHILE_LOW:
  assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(sda_oe_q) |-> !scl_in)
    else $error("Data pulled low while clock high");
  AST_HS_NACK:
  assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(hs_mode_q) |-> !sda_oe_q [*8])
    else $error("Master code acknowledged");
  AST_HS_EXIT:
  assert property (@(posedge link_clk) disable iff (!rst_b)
    hs_mode_q ##0 s_stop |-> ##[1:40] !hs_mode_q)
    else $error("Fast mode kept after stop");
  AST_STOP_RELEASE:
  assert property (@(posedge link_clk) disable iff (!rst_b)
    s_stop |-> ##[1:40] !sda_oe_q)
    else $error("Data held after stop");
endmodule : aitp_target_asserts

bind aitp_target aitp_target_asserts #(.ADDR_SEL(ADDR_SEL)) u_asserts (
  .core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q),
  .sda_oe_q(sda_oe_q), .conv_code(conv_code), .conv_done(conv_done),
  .conv_busy(conv_busy), .result_q(result_q), .cfg_q(cfg_q),
  .conv_start_q(conv_start_q), .gc_reset_q(gc_reset_q),
  .hs_mode_q(hs_mode_q)
);

//--- aitp_ctrl_model.sv
/*
  Bus controller model: owns the serial clock, pulls data low or lets go.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module aitp_ctrl_model (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  int qtr_n = 20;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic qtr();
    repeat (qtr_n) @(negedge core_clk);
  endtask : qtr
  // One clock pulse: data set while low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda;
    qtr();
    scl = 1'b0;
    qtr();
  endtask : bit_io
  task automatic start();
    sda_pull = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b0;
    qtr();
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask : rd_byte
endmodule : aitp_ctrl_model

//--- adc_i2c_target_port_test.sv
/*
  Self-checking bench of the two-wire target port.
  Assumes the controller model and the bound checker are compiled.
*/
`timescale 1ns/1ps
module adc_i2c_target_port_test;
  import aitp_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b, conv_done, conv_busy, scl, sda_pull, sda;
  logic [11:0] conv_code;
  logic sda_out_q, sda_oe_q, conv_start_q, gc_reset_q, hs_mode_q;
  logic [15:0] result_q, e, a;
  logic [7:0] cfg_q;
  logic [15:0] exp_q[$];
  logic [15:0] act_q[$];
  int num_errors = 0;
  int n_compared = 0;
  int n_start = 0;
  int n_gc = 0;
  // Open-drain wire: released means pulled up, enabled shows the pin value
  assign sda = ~sda_pull & (sda_oe_q ? sda_out_q : 1'b1);
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  aitp_target #(.ADDR_SEL(1'b0)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .conv_code(conv_code), .conv_done(conv_done),
    .conv_busy(conv_busy), .result_q(result_q), .cfg_q(cfg_q),
    .conv_start_q(conv_start_q), .gc_reset_q(gc_reset_q),
    .hs_mode_q(hs_mode_q)
  );
  aitp_ctrl_model m (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
  );
  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  always @(negedge core_clk) begin
    if (conv_start_q === 1'b1) n_start++;
    if (gc_reset_q === 1'b1) n_gc++;
  end
  initial forever begin
    @(posedge core_clk);
    while (act_q.size() > 0) begin
      e = exp_q.pop_front();
      a = act_q.pop_front();
      n_compared++;
      if (a !== e) begin
        num_errors++;
        $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
      end
    end
  end
  task automatic chk(input logic [15:0] ex, input logic [15:0] ac);
    exp_q.push_back(ex);
    act_q.push_back(ac);
  endtask : chk
  task automatic end_of_test();
    repeat (2) @(posedge core_clk);
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic send_addr(input logic [6:0] ad, input logic rw,
                           input logic ea);
    logic ack;
    m.start();
    m.wr_byte({ad, rw}, ack);
    chk(16'(ea), 16'(ack));
  endtask : send_addr
  task automatic rd_bytes(input logic [39:0] ex, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i != n - 1, d);
      chk(16'(ex[39 - 8 * i -: 8]), 16'(d));
    end
    m.stop();
    chk(16'h0000, 16'(sda_oe_q));
  endtask : rd_bytes
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic ack;
    logic [11:0] c;
    logic [15:0] r;
    logic [7:0] gc_code [3];
    void'($urandom(16));
    gc_code = '{8'h05, GC_ACK_CODE, GC_RESET_CODE};
    rst_b = 1'b0;
    conv_code = 12'h000;
    conv_done = 1'b0;
    conv_busy = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(RESULT_RESET, result_q);
    chk(16'(CFG_DEFAULT), 16'(cfg_q));
    c = 12'($urandom);
    conv_code = c;
    conv_done = 1'b1;
    @(negedge core_clk);
    conv_done = 1'b0;
    r = {{4{c[11]}}, c};
    repeat (30) @(negedge core_clk);
    chk(r, result_q);
    m.qtr_n = 63;
    send_addr(ADDR_OPT0, 1'b1, 1'b1);
    rd_bytes({r, CFG_DEFAULT, FILL_BYTE, FILL_BYTE}, 5);
    m.qtr_n = 20;
    send_addr(ADDR_OPT1, 1'b0, 1'b0);
    m.stop();
    send_addr(7'h4A, 1'b0, 1'b0);
    m.stop();
    send_addr(ADDR_OPT0, 1'b0, 1'b1);
    m.wr_byte(8'h93, ack);
    chk(16'h0001, 16'(ack));
    m.wr_byte(8'h55, ack);
    chk(16'h0000, 16'(ack));
    m.stop();
    chk(16'h0093, 16'(cfg_q));
    chk(16'h0001, 16'(n_start));
    conv_busy = 1'b1;
    repeat (30) @(negedge core_clk);
    send_addr(ADDR_OPT0, 1'b1, 1'b1);
    rd_bytes({r, 8'h93, 16'hFFFF}, 3);
    conv_busy = 1'b0;
    send_addr(ADDR_OPT0, 1'b0, 1'b1);
    repeat (3) m.bit_io(1'b0, ack);
    send_addr(ADDR_OPT0, 1'b1, 1'b1);
    rd_bytes({r[15:8], 32'hFFFF_FFFF}, 1);
    chk(16'h0093, 16'(cfg_q));
    send_addr(ADDR_OPT0, 1'b1, 1'b1);
    rd_bytes({r, 8'h13, 16'hFFFF}, 3);
    for (int i = 0; i < 3; i++) begin
      send_addr(7'h00, 1'b0, 1'b1);
      m.wr_byte(gc_code[i], ack);
      chk(16'(i != 0), 16'(ack));
      m.stop();
    end
    chk(16'h0001, 16'(n_gc));
    chk(RESULT_RESET, result_q);
    chk(16'(CFG_DEFAULT), 16'(cfg_q));
    m.start();
    m.wr_byte(8'h09, ack);
    chk(16'h0000, 16'(ack));
    chk(16'h0001, 16'(hs_mode_q));
    m.qtr_n = 6;
    send_addr(ADDR_OPT0, 1'b1, 1'b1);
    rd_bytes({RESULT_RESET, 24'hFF_FFFF}, 2);
    m.qtr_n = 20;
    chk(16'h0000, 16'(hs_mode_q));
    end_of_test();
  end
endmodule : adc_i2c_target_port_test
